/* File: ccl_params.svh */
`ifndef CCL_PARAMS_SVH
`define CCL_PARAMS_SVH

// per-channel page layout
`define CCL_NUM_CHANNELS      12
`define CCL_PAGE_LO_FIRST     4'h0
`define CCL_PAGE_LO_LAST      4'h5
`define CCL_PAGE_HI_FIRST     4'h8
`define CCL_PAGE_HI_LAST      4'hd
`define CCL_PAGE_HI_BASE_CH   6

// register offsets within a page
`define CCL_OFS_ENABLE        4'h1
`define CCL_OFS_CHANGE        4'h2
`define CCL_OFS_ALARM         4'h3

// field positions
`define CCL_BIT_FIFO_LIMIT    3
`define CCL_BIT_LOCK_LOST     2
`define CCL_BIT_SIGNAL_LOST   1
`define CCL_BIT_DRIVE_MON     0
`define CCL_FLAG_WIDTH        4

// reset values
`define CCL_RST_FLAGS         4'h0
`define CCL_RST_ENABLE        4'h0
`define CCL_RST_RDATA         8'h00

`endif

/* File: ccl_pkg.sv */
`default_nettype none

package ccl_pkg;

  // one channel's monitored conditions, bit 3 down to bit 0
  typedef struct packed {
    logic fifo_limit_alarm;
    logic receive_lock_lost;
    logic receive_signal_lost;
    logic drive_monitor_output;
  } ccl_cond_t;

  // one host register access
  typedef struct packed {
    logic [7:0] addr;
    logic       rd;
    logic       wr;
    logic [7:0] wdata;
  } ccl_req_t;

  typedef enum logic [1:0] {
    CCL_REG_NONE,
    CCL_REG_ENABLE,
    CCL_REG_CHANGE,
    CCL_REG_ALARM
  } ccl_reg_t;

endpackage

`default_nettype wire

/* File: ccl_channel_alarm_change_latch.sv */
`include "ccl_params.svh"
`default_nettype none


module ccl_channel_alarm_change_latch #(
  parameter int NUM_CH = `CCL_NUM_CHANNELS
) (
  // clock and reset
  input  wire logic                   CLK_SYS,
  input  wire logic                   RST_N,
  // monitored conditions, one group per channel
  input  wire ccl_pkg::ccl_cond_t [NUM_CH-1:0] CONDITION,
  // host register access
  input  wire ccl_pkg::ccl_req_t      HOST_REQ,
  output var  logic [7:0]             HOST_RDATA,
  output var  logic                   HOST_RVALID,
  // per-channel interrupt requests toward device-level aggregation
  output var  logic [NUM_CH-1:0]      CHANNEL_IRQ
);

  // ************************************************************
  // address decode
  // ************************************************************

  // maps a page nibble to a channel index; valid flag in bit 4
  function automatic logic [4:0] page_to_channel(input logic [3:0] page);
    logic [4:0] res;
    res = 5'h00;
    if (page >= `CCL_PAGE_LO_FIRST && page <= `CCL_PAGE_LO_LAST) begin
      res = {1'b1, page};
    end else if (page >= `CCL_PAGE_HI_FIRST && page <= `CCL_PAGE_HI_LAST) begin
      res = {1'b1, 4'(page - `CCL_PAGE_HI_FIRST + 4'(`CCL_PAGE_HI_BASE_CH))};
    end
    return res;
  endfunction

  function automatic ccl_pkg::ccl_reg_t reg_select(input logic [3:0] ofs);
    ccl_pkg::ccl_reg_t sel;
    sel = ccl_pkg::CCL_REG_NONE;
    case (ofs)
      `CCL_OFS_ENABLE: sel = ccl_pkg::CCL_REG_ENABLE;
      `CCL_OFS_CHANGE: sel = ccl_pkg::CCL_REG_CHANGE;
      `CCL_OFS_ALARM:  sel = ccl_pkg::CCL_REG_ALARM;
      default:         sel = ccl_pkg::CCL_REG_NONE;
    endcase
    return sel;
  endfunction

  logic [4:0]         dec_ch;
  logic [3:0]         ch_idx;
  logic               ch_ok;
  ccl_pkg::ccl_reg_t  dec_reg;

  always_comb begin
    dec_ch  = page_to_channel(HOST_REQ.addr[7:4]);
    ch_ok   = dec_ch[4] && (32'(dec_ch[3:0]) < NUM_CH);
    ch_idx  = dec_ch[3:0];
    dec_reg = reg_select(HOST_REQ.addr[3:0]);
  end

  // ************************************************************
  // per-channel latches
  // ************************************************************

  logic [NUM_CH-1:0][`CCL_FLAG_WIDTH-1:0] flags_q;
  logic [NUM_CH-1:0][`CCL_FLAG_WIDTH-1:0] enable_q;
  logic [NUM_CH-1:0][`CCL_FLAG_WIDTH-1:0] prev_q;

  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_ch
      logic [`CCL_FLAG_WIDTH-1:0] live;
      logic [`CCL_FLAG_WIDTH-1:0] change;
      logic                       hit;
      logic                       rd_clear;
      logic [`CCL_FLAG_WIDTH-1:0] flags_d;

      always_comb begin
        live     = CONDITION[g];
        change   = live ^ prev_q[g];
        hit      = ch_ok && (32'(ch_idx) == g);
        rd_clear = hit && HOST_REQ.rd && (dec_reg == ccl_pkg::CCL_REG_CHANGE);
        // a change in the clearing cycle survives the clear
        flags_d  = (flags_q[g] & {`CCL_FLAG_WIDTH{~rd_clear}}) | change;
      end

      // previous condition, for edge detection in either direction
      always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
          prev_q[g] <= `CCL_RST_FLAGS;
        end else begin
          prev_q[g] <= live;
        end
      end

      always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
          flags_q[g] <= `CCL_RST_FLAGS;
        end else begin
          flags_q[g] <= flags_d;
        end
      end

      always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
          enable_q[g] <= `CCL_RST_ENABLE;
        end else if (hit && HOST_REQ.wr && dec_reg == ccl_pkg::CCL_REG_ENABLE) begin
          enable_q[g] <= HOST_REQ.wdata[`CCL_FLAG_WIDTH-1:0];
        end
      end

      always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
          CHANNEL_IRQ[g] <= 1'b0;
        end else begin
          CHANNEL_IRQ[g] <= |(flags_d & enable_q[g]);
        end
      end
    end
  endgenerate

  // ************************************************************
  // read path
  // ************************************************************

  logic [7:0] rdata_d;

  always_comb begin
    rdata_d = `CCL_RST_RDATA;
    if (ch_ok) begin
      case (dec_reg)
        ccl_pkg::CCL_REG_ENABLE: rdata_d = {4'h0, enable_q[ch_idx]};
        ccl_pkg::CCL_REG_CHANGE: rdata_d = {4'h0, flags_q[ch_idx]};
        ccl_pkg::CCL_REG_ALARM:  rdata_d = {4'h0, CONDITION[ch_idx]};
        default:                 rdata_d = `CCL_RST_RDATA;
      endcase
    end
  end

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      HOST_RDATA <= `CCL_RST_RDATA;
    end else if (HOST_REQ.rd) begin
      HOST_RDATA <= rdata_d;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      HOST_RVALID <= 1'b0;
    end else begin
      HOST_RVALID <= HOST_REQ.rd;
    end
  end

endmodule

`default_nettype wire

/* File: ccl_chk.sv */
`default_nettype none
// ****
// checker
// ****
module ccl_chk #(
  parameter int NUM_CH = 12
) (
  // clock and reset
  input wire logic                             CLK_SYS,
  input wire logic                             RST_N,
  // watched ports
  input wire ccl_pkg::ccl_cond_t [NUM_CH-1:0] CONDITION,
  input wire ccl_pkg::ccl_req_t                HOST_REQ,
  input wire logic [7:0]                       HOST_RDATA,
  input wire logic                             HOST_RVALID,
  input wire logic [NUM_CH-1:0]                CHANNEL_IRQ
);
  wire logic       rd0 = HOST_REQ.rd && HOST_REQ.addr == 8'h02;
  wire logic [3:0] c0  = CONDITION[0];
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);
  property p_rv; HOST_REQ.rd |=> HOST_RVALID; endproperty
  a_rv: assert property (p_rv) else $error("read not answered");
  property p_hold; !HOST_REQ.rd |=> $stable(HOST_RDATA); endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_rsv; HOST_RVALID |-> HOST_RDATA[7:4] == 4'h0; endproperty
  a_rsv: assert property (p_rsv) else $error("upper bits set");
  property p_unm; HOST_REQ.rd && HOST_REQ.addr[6:5] == 2'b11 |=> HOST_RDATA == 8'h00; endproperty
  a_unm: assert property (p_unm) else $error("unmapped page data");
  property p_al; HOST_REQ.rd && HOST_REQ.addr == 8'h03 |=> HOST_RDATA == {4'h0, $past(c0)};
  endproperty
  a_al: assert property (p_al) else $error("alarm state wrong");
  property p_set; $changed(c0) ##1 rd0 |=> (~HOST_RDATA[3:0] & ($past(c0, 2) ^ $past(c0, 3)))
    == 4'h0; endproperty
  a_set: assert property (p_set) else $error("change lost");
  property p_clr; (rd0 && $stable(c0)) ##1 $stable(c0) ##1 rd0 |=> HOST_RDATA == 8'h00;
  endproperty
  a_clr: assert property (p_clr) else $error("flags not cleared");
  property p_irq; rd0 && $stable(c0) |=> !CHANNEL_IRQ[0]; endproperty
  a_irq: assert property (p_irq) else $error("irq after clear");
endmodule
`default_nettype wire

/* File: ccl_tb.sv */
`default_nettype none
// ****
// testbench
// ****
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic                     clk_sys = 1'b0;
  logic                     rst_n = 1'b0;
  ccl_pkg::ccl_cond_t [11:0] cond = '0;
  ccl_pkg::ccl_req_t        req = '0;
  logic [7:0]               rdata;
  logic                     rvalid;
  logic [11:0]              irq;
  logic [7:0]               pa;
  int                       ch;
  int                       miscompares = 0;
  int                       cmp_count = 0;
  always #2 clk_sys = ~clk_sys;
  ccl_channel_alarm_change_latch dut (.CLK_SYS(clk_sys), .RST_N(rst_n), .CONDITION(cond),
    .HOST_REQ(req), .HOST_RDATA(rdata), .HOST_RVALID(rvalid), .CHANNEL_IRQ(irq));
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    cmp_count++;
    if (s !== e) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", n, e, s);
    end
  endtask
  // one read strobe, answer checked the cycle after
  task automatic rc(input string n, input logic [7:0] a, input logic [7:0] e);
    @(negedge clk_sys);
    req.addr = a;
    req.rd = 1'b1;
    @(negedge clk_sys);
    req.rd = 1'b0;
    chk("rvalid", 8'h01, {7'h00, rvalid});
    chk(n, e, rdata);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge clk_sys);
    req.addr = a;
    req.wdata = v;
    req.wr = 1'b1;
    @(negedge clk_sys);
    req.wr = 1'b0;
  endtask
  task automatic conclude;
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    #100000;
    miscompares++;
    conclude();
  end
  initial begin
    repeat (2) @(negedge clk_sys);
    rst_n = 1'b1;
    for (int k = 0; k < 2; k++) begin
      ch = k ? 11 : 0;
      pa = k ? 8'hd0 : 8'h00;
      rc("idle", pa | 8'h02, 8'h00);
      for (int b = 0; b < 4; b++) begin
        @(negedge clk_sys);
        cond[ch][b] = 1'b1;
        rc("rise", pa | 8'h02, 8'h01 << b);
        rc("cleared", pa | 8'h02, 8'h00);
        rc("alarm", pa | 8'h03, 8'h01 << b);
        chk("irq off", 8'h00, {7'h00, irq[ch]});
        cond[ch][b] = 1'b0;
        rc("fall", pa | 8'h02, 8'h01 << b);
      end
      wr(pa | 8'h01, 8'hff);
      rc("enable", pa | 8'h01, 8'h0f);
      cond[ch][3] = 1'b1;
      @(negedge clk_sys);
      chk("irq on", 8'h01, {7'h00, irq[ch]});
      rc("flag", pa | 8'h02, 8'h08);
      chk("irq clr", 8'h00, {7'h00, irq[ch]});
      wr(pa | 8'h02, 8'hff);
      rc("no write", pa | 8'h02, 8'h00);
    end
    rc("unmapped", 8'h62, 8'h00);
    conclude();
  end
endmodule
bind ccl_channel_alarm_change_latch ccl_chk #(.NUM_CH(NUM_CH)) chk_i (.CLK_SYS(CLK_SYS),
  .RST_N(RST_N), .CONDITION(CONDITION), .HOST_REQ(HOST_REQ), .HOST_RDATA(HOST_RDATA),
  .HOST_RVALID(HOST_RVALID), .CHANNEL_IRQ(CHANNEL_IRQ));
`default_nettype wire
